// ===== clc_pkg.sv
// Purpose: shared constants, types and register map of the configurable logic cell
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   all offsets are byte addresses
package clc_pkg;

   // register byte offsets
   localparam logic [7:0]  CLC_CTRL_OFS   = 8'h00;
   localparam logic [7:0]  CLC_LUT_OFS    = 8'h04;
   localparam logic [7:0]  CLC_MCFG_OFS   = 8'h08;
   localparam logic [7:0]  CLC_STAT_OFS   = 8'h0C;

   // reset values
   localparam logic [4:0]  CLC_CTRL_RST   = 5'h00;
   localparam logic [15:0] CLC_LUT_RST    = 16'h0000;
   localparam logic [5:0]  CLC_MCFG_RST   = 6'h00;

   // field positions
   localparam int CLC_CTRL_MODE_LO  = 0;
   localparam int CLC_CTRL_CSEL     = 2;
   localparam int CLC_CTRL_CASC_EN  = 3;
   localparam int CLC_CTRL_CASC_OR  = 4;
   localparam int CLC_MCFG_TYPE_LO  = 0;
   localparam int CLC_MCFG_BYPASS   = 2;
   localparam int CLC_MCFG_CLK_SEL  = 3;
   localparam int CLC_MCFG_FALL0    = 4;
   localparam int CLC_MCFG_FALL1    = 5;
   localparam int CLC_STAT_CELL_Q   = 0;
   localparam int CLC_STAT_MC_Q     = 1;
   localparam int CLC_STAT_CARRY    = 2;
   localparam int CLC_STAT_CASC     = 3;
   localparam int CLC_STAT_CNT_LO   = 8;
   localparam int CLC_ARITH_CY_BASE = 8;   // carry table sits in the upper half of the mask

   // operating modes of the logic cell
   typedef enum logic [1:0] {
      CLC_MODE_NORMAL  = 2'b00,
      CLC_MODE_ARITH   = 2'b01,
      CLC_MODE_COUNTER = 2'b10,
      CLC_MODE_RSVD    = 2'b11
   } clc_mode_e;

   // macrocell register behaviour
   typedef enum logic [1:0] {
      CLC_FF_D  = 2'b00,
      CLC_FF_T  = 2'b01,
      CLC_FF_JK = 2'b10,
      CLC_FF_SR = 2'b11
   } clc_ff_e;

   // data inputs from local interconnect
   typedef struct packed {
      logic first_data_input;
      logic second_data_input;
      logic third_data_input;
      logic fourth_data_input;
      logic carry_in;
      logic cascade_in;
   } clc_cell_in_s;

   // macrocell configuration
   typedef struct packed {
      clc_ff_e ff_type;
      logic    bypass;
      logic    clk_sel;
      logic    fall0;
      logic    fall1;
   } clc_mcfg_s;

endpackage

// ===== clc_macro_reg.sv
// Purpose: programmable macrocell register (D, T, JK, SR) with bypass
// Assumes: tick_in is already the selected group clock edge qualified by its enable
// Notes:   bypass makes the output follow the primary input without a register
`timescale 1ns/1ps
module clc_macro_reg
   import clc_pkg::*;
(
   input  wire logic    clk_sys_in,   // system clock
   input  wire logic    rst_n_in,     // async reset, active low
   input  wire logic    tick_in,      // register update strobe
   input  wire clc_ff_e ff_type_in,   // register behaviour
   input  wire logic    bypass_in,    // combinational output when high
   input  wire logic    a_in,         // D, T, J or S input
   input  wire logic    b_in,         // K or R input
   output logic         reg_q_out,    // stored value
   output logic         q_out         // cell output
);

   logic reg_d;

   // next state per register type
   always_comb
   begin
      case (ff_type_in)
         CLC_FF_D:  reg_d = a_in;
         CLC_FF_T:  reg_d = reg_q_out ^ a_in;
         CLC_FF_JK: reg_d = (a_in & ~reg_q_out) | (~b_in & reg_q_out);
         CLC_FF_SR: reg_d = a_in | (~b_in & reg_q_out);             // set wins over reset
         default:   reg_d = reg_q_out;
      endcase
   end

   // storage only moves on the selected qualified edge
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         reg_q_out <= 1'b0;
      else if (tick_in)
         reg_q_out <= reg_d;
   end

   // bypass gives a purely combinational path
   assign q_out = bypass_in ? a_in : reg_q_out;

endmodule // clc_macro_reg

// ===== clc_cell.sv
// Purpose: configurable logic cell with lookup table, carry, cascade, counter and macrocell register
// Assumes: all inputs synchronous to clk_sys_in; group clocks arrive as sampled levels
// Notes:   zero-wait APB slave while clk_en_in is high; pslverr on unmapped or read-only write
`timescale 1ns/1ps
module clc_cell
   import clc_pkg::*;
#(
   parameter int CNT_W = 8                     // counter width
)
(
   input  wire logic              clk_sys_in,        // system clock, 20 MHz
   input  wire logic              rst_n_in,          // async reset, active low
   input  wire logic              clk_en_in,         // freezes all state when low
   // apb slave
   input  wire logic              psel,              // select
   input  wire logic              penable,           // access phase
   input  wire logic              pwrite,            // write when high
   input  wire logic [7:0]        paddr,             // byte address
   input  wire logic [31:0]       pwdata,            // write data
   output logic                   pready,            // transfer done
   output logic [31:0]            prdata,            // read data
   output logic                   pslverr,           // error answer
   // local interconnect
   input  wire clc_cell_in_s      cell_in,           // data, carry and cascade inputs
   input  wire logic              cell_ena_in,       // cell register clock enable
   input  wire logic              grp_sclr_in,       // group-wide synchronous clear
   input  wire logic              grp_sload_in,      // group-wide synchronous load
   input  wire logic [CNT_W-1:0]  load_data_in,      // value for synchronous load
   input  wire logic [1:0]        grp_clk_in,        // two group-wide clocks, sampled
   input  wire logic [1:0]        grp_clk_en_in,     // enable per group clock
   input  wire logic              mc_a_in,           // macrocell D/T/J/S input
   input  wire logic              mc_b_in,           // macrocell K/R input
   // results
   output logic                   lut_comb_out,      // unregistered table result
   output logic                   lut_reg_out,       // registered table result
   output logic                   carry_out,         // carry chain out
   output logic                   cascade_out,       // cascade chain out
   output logic [CNT_W-1:0]       count_out,         // counter value
   output logic                   mc_out             // macrocell output
);

   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   logic [4:0]       ctrl_q;
   logic [15:0]      lut_q;
   clc_mcfg_s        mcfg_q;
   logic [1:0]       clk_prev_q;
   logic [1:0]       clk_edge;
   logic             mc_tick;
   logic             mc_reg_q;
   logic             cell_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   clc_mode_e        mode;
   logic             apb_wr;
   logic             apb_rd;
   logic             addr_ok;
   logic [2:0]       arith_idx;
   logic [3:0]       norm_idx;
   logic             norm_res;
   logic             sum_res;
   logic             cy_res;
   logic             table_res;
   logic             cell_tick;
   logic             cnt_en;
   logic             cnt_up;

   // pick one bit of the configuration mask
   function automatic logic lut_pick(input logic [15:0] mask, input logic [3:0] idx);
      lut_pick = mask[idx];
   endfunction

   // true for an address that maps to a register
   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == CLC_CTRL_OFS) || (a == CLC_LUT_OFS) || (a == CLC_MCFG_OFS) || (a == CLC_STAT_OFS);
   endfunction

   assign mode = clc_mode_e'(ctrl_q[CLC_CTRL_MODE_LO +: 2]);

   // apb decode; answer held off while the cell is frozen
   assign addr_ok = addr_hit(paddr);
   assign pready  = clk_en_in;
   assign apb_wr  = psel & penable & pwrite & clk_en_in;
   assign apb_rd  = psel & penable & ~pwrite;
   assign pslverr = psel & penable & (~addr_ok | (pwrite & (paddr == CLC_STAT_OFS)));

   // control register writes
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_q <= CLC_CTRL_RST;
         lut_q  <= CLC_LUT_RST;
         mcfg_q <= clc_mcfg_s'(CLC_MCFG_RST);
      end
      else if (apb_wr)
      begin
         case (paddr)
            CLC_CTRL_OFS: ctrl_q <= pwdata[4:0];
            CLC_LUT_OFS:  lut_q  <= pwdata[15:0];
            CLC_MCFG_OFS: mcfg_q <= clc_mcfg_s'({pwdata[CLC_MCFG_TYPE_LO +: 2], pwdata[CLC_MCFG_BYPASS],
                                                 pwdata[CLC_MCFG_CLK_SEL], pwdata[CLC_MCFG_FALL0],
                                                 pwdata[CLC_MCFG_FALL1]});
            default:      ctrl_q <= ctrl_q;
         endcase
      end
   end

   // read mux; status word shows the live cell state
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (apb_rd)
      begin
         case (paddr)
            CLC_CTRL_OFS: prdata[4:0]  = ctrl_q;
            CLC_LUT_OFS:  prdata[15:0] = lut_q;
            CLC_MCFG_OFS:
            begin
               prdata[CLC_MCFG_TYPE_LO +: 2] = mcfg_q.ff_type;
               prdata[CLC_MCFG_BYPASS]       = mcfg_q.bypass;
               prdata[CLC_MCFG_CLK_SEL]      = mcfg_q.clk_sel;
               prdata[CLC_MCFG_FALL0]        = mcfg_q.fall0;
               prdata[CLC_MCFG_FALL1]        = mcfg_q.fall1;
            end
            CLC_STAT_OFS:
            begin
               prdata[CLC_STAT_CELL_Q]          = cell_q;
               prdata[CLC_STAT_MC_Q]            = mc_reg_q;
               prdata[CLC_STAT_CARRY]           = carry_out;
               prdata[CLC_STAT_CASC]            = cascade_out;
               prdata[CLC_STAT_CNT_LO +: CNT_W] = count_q;
            end
            default:      prdata = 32'h0000_0000;
         endcase
      end
   end

   // table indices; normal mode swaps third input for carry-in on request
   assign norm_idx  = {cell_in.fourth_data_input,
                       ctrl_q[CLC_CTRL_CSEL] ? cell_in.carry_in : cell_in.third_data_input,
                       cell_in.second_data_input, cell_in.first_data_input};
   assign arith_idx = {cell_in.carry_in, cell_in.second_data_input, cell_in.first_data_input};
   assign norm_res  = lut_pick(lut_q, norm_idx);
   assign sum_res   = lut_pick(lut_q, {1'b0, arith_idx});
   assign cy_res    = lut_pick(lut_q, 4'(CLC_ARITH_CY_BASE) | {1'b0, arith_idx});
   assign table_res = (mode == CLC_MODE_ARITH) ? sum_res : norm_res;

   // cascade chain available in normal and arithmetic mode
   always_comb
   begin
      if (ctrl_q[CLC_CTRL_CASC_EN] && (mode != CLC_MODE_COUNTER))
         cascade_out = ctrl_q[CLC_CTRL_CASC_OR] ? (table_res | cell_in.cascade_in)
                                                : (table_res & cell_in.cascade_in);
      else
         cascade_out = table_res;
   end

   // carry out: adder carry, or terminal count so counter cells can chain
   always_comb
   begin
      case (mode)
         CLC_MODE_ARITH:   carry_out = cy_res;
         CLC_MODE_COUNTER: carry_out = cnt_up ? (&count_q) : ~(|count_q);
         default:          carry_out = 1'b0;
      endcase
   end

   assign lut_comb_out = table_res;
   assign lut_reg_out  = cell_q;

   // cell register holds the table result
   assign cell_tick = clk_en_in & cell_ena_in;
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cell_q <= 1'b0;
      else if (cell_tick && (mode != CLC_MODE_COUNTER))
         cell_q <= table_res;
   end

   // counter controls come from the cell's own data inputs
   assign cnt_en = cell_in.first_data_input;
   assign cnt_up = cell_in.second_data_input;

   // clear over load over count; group lines act only on the counter register
   always_comb
   begin
      if (grp_sclr_in)
         count_d = CNT_ZERO;
      else if (grp_sload_in)
         count_d = load_data_in;
      else if (cnt_en)
         count_d = cnt_up ? CNT_W'(count_q + CNT_ONE) : CNT_W'(count_q - CNT_ONE);
      else
         count_d = count_q;
   end

   // counter register, gated by the cell clock enable
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         count_q <= CNT_ZERO;
      else if (cell_tick && (mode == CLC_MODE_COUNTER))
         count_q <= count_d;
   end

   assign count_out = count_q;

   // previous sampled level of both group clocks; one process keeps a single driver
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         clk_prev_q <= 2'h0;
      else if (clk_en_in)
         clk_prev_q <= grp_clk_in;
   end

   // edge detect per group clock; each may be set to rising or falling
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_clk
         logic fall_sel;
         assign fall_sel = (g == 0) ? mcfg_q.fall0 : mcfg_q.fall1;
         // a mixed-edge group programs one clock per edge
         assign clk_edge[g] = fall_sel ? (clk_prev_q[g] & ~grp_clk_in[g])
                                       : (~clk_prev_q[g] & grp_clk_in[g]);
      end
   endgenerate

   // selected clock always travels with its own enable
   assign mc_tick = clk_en_in & clk_edge[mcfg_q.clk_sel] & grp_clk_en_in[mcfg_q.clk_sel];

   clc_macro_reg u_macro
   (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .tick_in    (mc_tick),
      .ff_type_in (mcfg_q.ff_type),
      .bypass_in  (mcfg_q.bypass),
      .a_in       (mc_a_in),
      .b_in       (mc_b_in),
      .reg_q_out  (mc_reg_q),
      .q_out      (mc_out)
   );

   // checks
   sequence s_count_step;
      clk_en_in && cell_ena_in && (mode == CLC_MODE_COUNTER) && !grp_sclr_in && !grp_sload_in && cnt_en;
   endsequence

   sequence s_arith_capture;
      cell_tick && (mode == CLC_MODE_ARITH);
   endsequence

   sequence s_clk0_rise;
      clk_en_in && !mcfg_q.fall0 && !grp_clk_in[0] ##1 clk_en_in && !mcfg_q.fall0 && grp_clk_in[0];
   endsequence

   sequence s_clk1_fall;
      clk_en_in && mcfg_q.fall1 && grp_clk_in[1] ##1 clk_en_in && mcfg_q.fall1 && !grp_clk_in[1];
   endsequence

   AST_NORM_SEL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (mode == CLC_MODE_NORMAL) |-> lut_comb_out == lut_q[{cell_in.fourth_data_input,
         ctrl_q[CLC_CTRL_CSEL] ? cell_in.carry_in : cell_in.third_data_input,
         cell_in.second_data_input, cell_in.first_data_input}])
      else $error("normal mode table output wrong");

   AST_CASC_AND: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      ((mode != CLC_MODE_COUNTER) && ctrl_q[CLC_CTRL_CASC_EN] && !ctrl_q[CLC_CTRL_CASC_OR] && !cell_in.cascade_in)
      |-> !cascade_out)
      else $error("cascade low did not force cascade out low");

   AST_SUM_REG: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_arith_capture |=> lut_reg_out == $past(lut_q[{1'b0, arith_idx}]))
      else $error("registered sum not captured");

   AST_CARRY: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (mode == CLC_MODE_ARITH) |-> carry_out == lut_q[{1'b1, arith_idx}])
      else $error("carry out does not follow carry table");

   AST_COUNT_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_count_step |=> count_out == ($past(cnt_up) ? CNT_W'($past(count_out) + CNT_ONE)
                                                   : CNT_W'($past(count_out) - CNT_ONE)))
      else $error("counter step wrong");

   AST_COUNT_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (!cnt_en && !grp_sclr_in && !grp_sload_in) |=> $stable(count_out))
      else $error("counter moved without count enable");

   AST_CLR_WINS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (cell_tick && (mode == CLC_MODE_COUNTER) && grp_sclr_in) |=> (count_out == CNT_ZERO))
      else $error("synchronous clear not applied");

   AST_LOAD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (cell_tick && (mode == CLC_MODE_COUNTER) && !grp_sclr_in && grp_sload_in)
      |=> count_out == $past(load_data_in))
      else $error("synchronous load not applied");

   AST_MC_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !grp_clk_en_in[mcfg_q.clk_sel] |=> $stable(mc_reg_q))
      else $error("macrocell moved with its clock enable low");

   AST_MC_D: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      (mc_tick && (mcfg_q.ff_type == CLC_FF_D)) |=> mc_reg_q == $past(mc_a_in))
      else $error("d register did not capture");

   AST_BYPASS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      mcfg_q.bypass |-> mc_out == mc_a_in)
      else $error("bypass output not combinational");

   AST_FALL_EDGE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_clk1_fall |-> clk_edge[1])
      else $error("falling edge of group clock missed");

   AST_RISE_EDGE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      s_clk0_rise |-> clk_edge[0])
      else $error("rising edge of group clock missed");

   AST_CASC_ARITH: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      ((mode == CLC_MODE_ARITH) && ctrl_q[CLC_CTRL_CASC_EN]) |-> cascade_out == (ctrl_q[CLC_CTRL_CASC_OR]
         ? (lut_comb_out | cell_in.cascade_in) : (lut_comb_out & cell_in.cascade_in)))
      else $error("cascade chain lost in arithmetic mode");

   AST_FREEZE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !clk_en_in |=> ($stable(count_out) && $stable(lut_reg_out) && $stable(mc_reg_q)))
      else $error("state moved while clock enable low");

endmodule // clc_cell

// ===== clc_nbr_model.sv
// Purpose: neighbouring cell that feeds carry and cascade into the cell
// Assumes: the upstream cell is a plain adder stage
// Notes:   purely combinational, so it never joins a counter
`timescale 1ns/1ps
module clc_nbr_model
(
   input  wire logic a_in,      // upstream first input
   input  wire logic b_in,      // upstream second input
   input  wire logic c_in,      // upstream carry in
   output logic      carry_out, // carry towards the cell
   output logic      casc_out   // cascade towards the cell
);
   // upstream stays combinational, as a group holding a counter demands
   assign carry_out = (a_in & b_in) | (c_in & (a_in | b_in)); // carry
   assign casc_out  = a_in ^ b_in ^ c_in;                     // sum bit
endmodule // clc_nbr_model

// ===== tb_top.sv
// Purpose: self-checking bench for the configurable logic cell
// Assumes: zero-wait APB slave, CNT_W of 8
// Notes:   every APB answer is compared against a queued note
`timescale 1ns/1ps
module tb_top;
   import clc_pkg::*;
   typedef struct packed {
      logic [31:0] v; // expected read data
      logic [31:0] m; // data bits compared
      logic        e; // expected error
      logic [1:0]  s; // pin checked: 1 table, 2 macro
      logic        c; // expected pin value
   } clc_note_s;
   logic         clk_sys_in = 0, rst_n_in = 0, clk_en_in = 1;
   logic         psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0]   paddr = '0, load_data_in = '0, m_cnt = '0;
   logic [31:0]  pwdata = '0, prdata;
   logic         cell_ena_in = 0, grp_sclr_in = 0, grp_sload_in = 0, mc_a_in = 0, mc_b_in = 0;
   logic [1:0]   grp_clk_in = '0, grp_clk_en_in = '0;
   logic [3:0]   dv = '0;
   logic [2:0]   up = '0;
   logic         ncy, ncs, lut_comb_out, lut_reg_out, carry_out, cascade_out, mc_out, m_mc = 0;
   logic [7:0]   count_out;
   logic [5:0]   mcfg;
   clc_cell_in_s cell_in;
   clc_note_s    notes[$];
   int           err_count = 0, n_tests = 0;

   // first data input sits in the top bit of the struct
   assign cell_in = {dv[0], dv[1], dv[2], dv[3], ncy, ncs};
   always #25 clk_sys_in = ~clk_sys_in;

   clc_nbr_model i_clc_nbr_model (.a_in(up[0]), .b_in(up[1]), .c_in(up[2]), .carry_out(ncy), .casc_out(ncs));
   clc_cell #(.CNT_W(8)) i_clc_cell (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .cell_in(cell_in), .cell_ena_in(cell_ena_in),
      .grp_sclr_in(grp_sclr_in), .grp_sload_in(grp_sload_in), .load_data_in(load_data_in),
      .grp_clk_in(grp_clk_in), .grp_clk_en_in(grp_clk_en_in), .mc_a_in(mc_a_in), .mc_b_in(mc_b_in),
      .lut_comb_out(lut_comb_out), .lut_reg_out(lut_reg_out), .carry_out(carry_out),
      .cascade_out(cascade_out), .count_out(count_out), .mc_out(mc_out));

   task automatic bad(input string msg);
      $display("BAD %0t %s", $time, msg);
      err_count++;
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input clc_note_s n);
      @(posedge clk_sys_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      notes.push_back(n);
      @(posedge clk_sys_in);
      penable <= 1'b1;
      @(posedge clk_sys_in);
      while (pready !== 1'b1)
         @(posedge clk_sys_in);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] v, m, input logic e, input logic [1:0] s,
                     input logic c);
      apb(1'b0, a, 32'h0, '{v, m, e, s, c});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, '{32'h0, 32'h0, e, 2'd0, 1'b0});
   endtask

   // counter run of k edges, then frozen and read back
   task automatic cnt_run(input logic ce, en, d1, d2, clr, ld, input int k);
      logic [7:0] ldv;
      logic       tc;
      ldv = 8'($urandom());
      @(posedge clk_sys_in);
      clk_en_in    <= ce;
      cell_ena_in  <= en;
      dv           <= {2'b00, d2, d1};
      grp_sclr_in  <= clr;
      grp_sload_in <= ld;
      load_data_in <= ldv;
      repeat (k) @(posedge clk_sys_in);
      clk_en_in    <= 1'b1;
      cell_ena_in  <= 1'b0;
      grp_sclr_in  <= 1'b0;
      grp_sload_in <= 1'b0;
      if (ce && en)
         repeat (k) m_cnt = clr ? 8'h00 : ld ? ldv : d1 ? (d2 ? m_cnt + 8'h01 : m_cnt - 8'h01) : m_cnt;
      // terminal count on carry out follows the direction input
      tc = d2 ? (m_cnt == 8'hFF) : (m_cnt == 8'h00);
      rd(CLC_STAT_OFS, {16'h0, m_cnt, 5'h0, tc, 2'h0}, 32'h0000FF04, 1'b0, 2'd0, 1'b0); // count
   endtask

   // level before the edge, then one edge; enable only in the edge cycle
   task automatic mc_tick(input logic sel, fall, en, a, b);
      @(posedge clk_sys_in);
      grp_clk_in[sel] <= fall;
      @(posedge clk_sys_in);
      grp_clk_in[sel]    <= ~fall;
      grp_clk_en_in[sel] <= en;
      mc_a_in            <= a;
      mc_b_in            <= b;
      @(posedge clk_sys_in);
      grp_clk_en_in <= 2'b00;
      if (en && sel == mcfg[3] && fall == mcfg[4 + sel])
         case (mcfg[1:0])
            2'd0: m_mc = a;
            2'd1: m_mc = m_mc ^ a;
            2'd2: m_mc = (a & b) ? ~m_mc : a ? 1'b1 : b ? 1'b0 : m_mc;
            default: m_mc = a ? 1'b1 : b ? 1'b0 : m_mc;
         endcase
      rd(CLC_STAT_OFS, {30'h0, m_mc, 1'b0}, 32'h2, 1'b0, 2'd2, mcfg[2] ? a : m_mc);
   endtask

   // compares each finished transfer with the oldest note
   always @(posedge clk_sys_in)
   begin
      if (psel && penable && pready === 1'b1 && notes.size() > 0)
      begin
         clc_note_s n;
         n = notes.pop_front();
         n_tests++;
         if ((prdata & n.m) !== n.v || pslverr !== n.e || (n.s == 2'd1 && lut_comb_out !== n.c)
             || (n.s == 2'd2 && mc_out !== n.c)
             || (paddr == CLC_STAT_OFS && n.m[0] && lut_reg_out !== n.v[0])
             || (paddr == CLC_STAT_OFS && n.m[2] && carry_out !== n.v[2])
             || (paddr == CLC_STAT_OFS && n.m[3] && cascade_out !== n.v[3])
             || (paddr == CLC_STAT_OFS && n.m[8] && count_out !== n.v[15:8]))
            bad($sformatf("addr %h read %h err %b", paddr, prdata, pslverr));
      end
   end

   // watchdog well beyond the expected few hundred cycles
   initial
   begin
      #2000000;
      bad("watchdog expired");
      complete_run();
   end

   initial
   begin
      logic [15:0] msk;
      logic [4:0]  ctl;
      logic [2:0]  j;
      logic        t, cy, cs;
      void'($urandom(30));
      repeat (16) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      // reset values and refused accesses
      rd(CLC_CTRL_OFS, 32'h0, '1, 1'b0, 2'd1, 1'b0); // reset, table out low
      rd(CLC_LUT_OFS, 32'h0, '1, 1'b0, 2'd0, 1'b0);
      rd(CLC_MCFG_OFS, 32'h0, '1, 1'b0, 2'd2, 1'b0); // register cleared
      rd(8'h10, 32'h0, '1, 1'b1, 2'd0, 1'b0);
      wr(CLC_STAT_OFS, 32'hFFFFFFFF, 1'b1);
      // normal and arithmetic modes with random tables
      for (int i = 0; i < 32; i++)
      begin
         msk = 16'($urandom());
         ctl = {3'($urandom()), 1'b0, i[0]};
         wr(CLC_LUT_OFS, {16'h0, msk}, 1'b0);
         wr(CLC_CTRL_OFS, {27'h0, ctl}, 1'b0);
         @(posedge clk_sys_in);
         dv          <= 4'($urandom());
         up          <= 3'($urandom());
         cell_ena_in <= 1'b1;
         @(negedge clk_sys_in);
         j  = {cell_in.carry_in, dv[1], dv[0]};
         t  = ctl[0] ? msk[j] : msk[{dv[3], ctl[2] ? cell_in.carry_in : dv[2], dv[1], dv[0]}];
         cy = ctl[0] ? msk[8 + j] : 1'b0;
         cs = ctl[3] ? (ctl[4] ? t | cell_in.cascade_in : t & cell_in.cascade_in) : t;
         rd(CLC_STAT_OFS, {28'h0, cs, cy, 1'b0, t}, 32'hD, 1'b0, 2'd1, t); // table
      end
      // counter mode: load, count, hold, priority
      wr(CLC_CTRL_OFS, 32'h2, 1'b0);
      cnt_run(1, 1, 0, 0, 0, 1, 1); // load
      cnt_run(1, 1, 1, 1, 0, 0, 3); // up
      cnt_run(1, 1, 1, 0, 0, 0, 5); // down
      cnt_run(1, 1, 0, 1, 0, 0, 2); // count enable off
      cnt_run(1, 0, 1, 1, 0, 0, 2); // clock enable off
      cnt_run(0, 1, 1, 1, 0, 0, 3); // global freeze
      cnt_run(1, 1, 1, 1, 1, 1, 1); // clear beats load
      cnt_run(1, 1, 1, 0, 0, 0, 1); // wrap below zero
      cnt_run(1, 1, 1, 0, 0, 1, 1); // load beats count
      // macrocell: every type, both clocks and edges, then bypass
      for (int i = 0; i < 40; i++)
      begin
         if (i % 4 == 0)
         begin
            mcfg      = 6'($urandom());
            mcfg[1:0] = 2'(i / 4);
            mcfg[2]   = (i >= 32);
            wr(CLC_MCFG_OFS, {26'h0, mcfg}, 1'b0);
         end
         mc_tick(1'($urandom()), 1'($urandom()), ($urandom() % 4) != 0, 1'($urandom()), 1'($urandom()));
      end
      complete_run();
   end
endmodule // tb_top
